// *** include/clkgen_defines.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with byte addresses, one word per register
//
// Summary of operation
// RULE1 - power-up loads defaults from nonvolatile store
// RULE2 - no bus access until initialization ends
// RULE3 - clock outputs inactive until initialization done
// RULE4 - hard reset reloads everything like power-up
// RULE5 - hard reset from pin or register bit
// RULE6 - soft reset applies pending config, no reload
// RULE7 - output divider even, 2 to 2^25-2
// RULE8 - crosspoint routes any synth divider anywhere
// RULE9 - register picks crystal or external clock mode
// RULE10 - bit picks pin or register input select
// RULE11 - pin codes 00,01,10 inputs; 11 crystal
// RULE12 - select pins pulled up, open reads one
// RULE13 - monitor signal loss and pll lock loss
// RULE14 - status readable; lock state on low pin
// RULE15 - sticky flag per status bit until cleared
// RULE16 - writing zero clears a sticky flag
// RULE17 - interrupt pin asserts on status change
// RULE18 - mask bit per source blocks interrupt
// RULE19 - interrupt releases once flags are cleared
// RULE20 - twelve outputs, each diff or single-ended
// RULE21 - irq low while unmasked flag set
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

`define A_CTRL      12'h000
`define A_INSEL     12'h004
`define A_STATUS    12'h008
`define A_FLAG      12'h00C
`define A_MASK      12'h010
`define A_FMT       12'h014
`define A_OUTEN     12'h018
`define A_XSEL      12'h070
`define A_LAST_XSEL 12'h09C
`define A_RDIV      12'h040
`define A_LAST_RDIV 12'h06C

`define B_HARD      0
`define B_SOFT      1
`define B_XTAL_EXT  2
`define B_REG_SEL   3
`define B_INIT_DONE 8

`define N_INPUTS    5
`define N_OUTS      12
`define N_SYNTH     5
`define RDIV_W      25
`define RDIV_MIN    25'h0000002
`define RDIV_MAX    25'h1FFFFFE
`define NVM_WORDS   16
`define INIT_CYCLES 256
`define RST_MASK    5'h00
`define RST_FMT     12'hFFF
`endif

// *** include/clkgen_pkg.sv ***
// types shared by the clock generator control block
// assumes clkgen_defines.svh is on the include path
`include "clkgen_defines.svh"
package clkgen_pkg;
  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_RUN  = 3'b010,
    ST_SOFT = 3'b100
  } init_state_e;
  typedef struct packed {
    logic [4:0] lost;   // 4 feedback, 3 crystal, 2..0 ref inputs; lock kept apart... see map
  } monitor_s;
  typedef logic [3:0] xsel_t;
endpackage

// *** rtl/clock_gen_ctrl_status.sv ***
// control and status logic of a twelve-output clock generator
// assumes synchronous pins, apb master, nonvolatile store as constant table
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_ctrl_status
  import clkgen_pkg::*;
#(
  parameter int INIT_CYCLES = `INIT_CYCLES
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        hard_reset_pin_n,
  input  wire logic [1:0]  in_sel_pins,
  // monitors: 0..2 ref inputs, 3 crystal, 4 feedback
  input  wire logic [4:0]  signal_missing,
  input  wire logic        lock_lost,
  output logic             lock_fail_pin_n,
  output logic             irq_pin_n,
  // analog side config
  output logic             clocks_enable,
  output logic             crystal_ext_mode,
  output logic [1:0]       active_ref,
  output logic [`N_OUTS-1:0] out_single_ended,
  output logic [`N_OUTS-1:0] out_enable,
  output logic [`N_OUTS*4-1:0] out_xsel,
  output logic [`N_OUTS*`RDIV_W-1:0] out_rdiv
);
  initial begin
    if (INIT_CYCLES < `NVM_WORDS) $error("INIT_CYCLES too small");
  end

  localparam int NS = 6;

  // pending (shadow) and applied configuration
  logic [31:0] ctrl_q, ctrl_d;
  logic [1:0]  insel_q, insel_d;
  logic [NS-1:0] mask_q, mask_d, flag_q, flag_d, stat_q;
  logic [`N_OUTS-1:0] fmt_q, fmt_d, oen_q, oen_d;
  xsel_t xs_q [`N_OUTS];
  xsel_t xs_d [`N_OUTS];
  logic [`RDIV_W-1:0] rd_q [`N_OUTS];
  logic [`RDIV_W-1:0] rd_d [`N_OUTS];
  init_state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic        hreq_q, hreq_d;

  // nonvolatile defaults: divider value per output
  function automatic logic [`RDIV_W-1:0] nvm_rdiv(input int i);
    nvm_rdiv = `RDIV_W'(2 * (i + 1));
  endfunction

  function automatic logic rdiv_ok(input logic [31:0] v);
    rdiv_ok = (v[0] == 1'b0) && (v[`RDIV_W-1:0] >= `RDIV_MIN)
              && (v[31:`RDIV_W] == '0);
  endfunction

  wire logic acc   = psel && penable && pready && (st_q == ST_RUN); // RULE2
  wire logic wr    = acc && pwrite;
  wire logic in_rd = (paddr >= `A_RDIV) && (paddr <= `A_LAST_RDIV);
  wire logic in_xs = (paddr >= `A_XSEL) && (paddr <= `A_LAST_XSEL);
  wire logic [3:0] rdi  = 4'((paddr - `A_RDIV) >> 2);
  wire logic [3:0] xsi  = 4'((paddr - `A_XSEL) >> 2);
  wire logic [NS-1:0] mon = {lock_lost, signal_missing}; // RULE13

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    ctrl_d  = ctrl_q;
    insel_d = insel_q;
    mask_d  = mask_q;
    fmt_d   = fmt_q;
    oen_d   = oen_q;
    hreq_d  = 1'b0;
    xs_d    = xs_q;
    rd_d    = rd_q;
    flag_d  = flag_q;
    case (st_q)
      ST_LOAD: begin
        // reload from the store one cycle per step; RULE1 RULE4
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q < 16'(`NVM_WORDS)) begin
          for (int i = 0; i < `N_OUTS; i++) begin
            rd_d[i] = nvm_rdiv(i);
            xs_d[i] = 4'(i % `N_SYNTH);
          end
          ctrl_d  = 32'h0;
          insel_d = 2'h0;
          mask_d  = NS'(`RST_MASK);
          fmt_d   = `RST_FMT;
          oen_d   = '1;
          flag_d  = '0;
        end
        if (cnt_q == 16'(INIT_CYCLES - 1)) st_d = ST_RUN;
      end
      ST_SOFT: st_d = ST_RUN; // RULE6
      ST_RUN: begin
        if (wr) begin
          case (paddr)
            `A_CTRL: begin
              ctrl_d = {28'h0, pwdata[`B_XTAL_EXT+:2], 2'b00} |
                       (pwdata & 32'h0000000C);
              hreq_d = pwdata[`B_HARD]; // RULE5
              if (pwdata[`B_SOFT]) st_d = ST_SOFT; // RULE6
            end
            `A_INSEL: insel_d = pwdata[1:0];
            `A_MASK:  mask_d  = pwdata[NS-1:0]; // RULE18
            `A_FLAG:  flag_d  = flag_q & pwdata[NS-1:0]; // RULE16
            `A_FMT:   fmt_d   = pwdata[`N_OUTS-1:0]; // RULE20
            `A_OUTEN: oen_d   = pwdata[`N_OUTS-1:0];
            default: begin
              if (in_xs && pwdata[3:0] < 4'(`N_SYNTH))
                xs_d[xsi] = pwdata[3:0]; // RULE8
              if (in_rd && rdiv_ok(pwdata))
                rd_d[rdi] = pwdata[`RDIV_W-1:0]; // RULE7
            end
          endcase
        end
        // set wins over clear; RULE15
        flag_d = flag_d | mon;
        if (!hard_reset_pin_n || hreq_q) begin // RULE5 RULE4
          st_d  = ST_LOAD;
          cnt_d = 16'h0;
        end
      end
      default: st_d = ST_LOAD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_LOAD;
      cnt_q   <= 16'h0;
      ctrl_q  <= 32'h0;
      insel_q <= 2'h0;
      mask_q  <= '0;
      flag_q  <= '0;
      fmt_q   <= '0;
      oen_q   <= '0;
      hreq_q  <= 1'b0;
      stat_q  <= '0;
      for (int i = 0; i < `N_OUTS; i++) begin
        xs_q[i] <= 4'h0;
        rd_q[i] <= `RDIV_MIN;
      end
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      ctrl_q  <= ctrl_d;
      insel_q <= insel_d;
      mask_q  <= mask_d;
      flag_q  <= flag_d;
      fmt_q   <= fmt_d;
      oen_q   <= oen_d;
      hreq_q  <= hreq_d;
      stat_q  <= mon; // RULE14
      xs_q    <= xs_d;
      rd_q    <= rd_d;
    end
  end

  // applied outputs: pending values other than the input select and the interrupt mask take effect at soft reset or init end
  logic apply;
  assign apply = (st_q == ST_SOFT) ||
                 (st_q == ST_LOAD && st_d == ST_RUN);
  logic [1:0] ref_d;
  always_comb begin
    // pins used directly; undriven pins are pulled up to 11; RULE12
    if (ctrl_q[`B_REG_SEL]) ref_d = insel_q; // RULE10
    else ref_d = in_sel_pins; // RULE11
  end

  logic [31:0] rdat;
  always_comb begin
    rdat = 32'h0;
    case (paddr)
      `A_CTRL:   rdat = ctrl_q | 32'(1 << `B_INIT_DONE);
      `A_INSEL:  rdat = {30'h0, insel_q};
      `A_STATUS: rdat = 32'(stat_q);
      `A_FLAG:   rdat = 32'(flag_q);
      `A_MASK:   rdat = 32'(mask_q);
      `A_FMT:    rdat = 32'(fmt_q);
      `A_OUTEN:  rdat = 32'(oen_q);
      default: begin
        if (in_xs) rdat = 32'(xs_q[xsi]);
        if (in_rd) rdat = 32'(rd_q[rdi]);
      end
    endcase
  end
  wire logic mapped = in_xs || in_rd || (paddr <= `A_OUTEN && paddr[1:0]==2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata           <= 32'h0;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      irq_pin_n        <= 1'b1;
      lock_fail_pin_n  <= 1'b1;
      clocks_enable    <= 1'b0;
      crystal_ext_mode <= 1'b0;
      active_ref       <= 2'h3;
      out_single_ended <= '0;
      out_enable       <= '0;
      out_xsel         <= '0;
      out_rdiv         <= '0;
    end else begin
      // pready held low during load: bus stalls until init is done; RULE2
      pready  <= psel && (st_d == ST_RUN) && !pready;
      pslverr <= psel && (st_d == ST_RUN) && !pready && !mapped;
      prdata  <= rdat;
      irq_pin_n <= ~|(flag_d & ~mask_d); // RULE17 RULE19 RULE21
      lock_fail_pin_n <= ~lock_lost; // RULE14
      clocks_enable <= (st_d != ST_LOAD); // RULE3
      if (st_d == ST_LOAD) out_enable <= '0; // RULE3
      if (apply) begin
        crystal_ext_mode <= ctrl_q[`B_XTAL_EXT]; // RULE9
        out_single_ended <= fmt_q;
        out_enable       <= oen_q;
        for (int i = 0; i < `N_OUTS; i++) begin
          out_xsel[i*4+:4]           <= xs_q[i]; // RULE8
          out_rdiv[i*`RDIV_W+:`RDIV_W] <= rd_q[i];
        end
      end
      active_ref <= ref_d;
    end
  end

  // assertions
  property p_no_clk_in_load;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_LOAD) |-> !clocks_enable;
  endproperty
  a_no_clk_in_load: assert property (p_no_clk_in_load) // RULE3
    else $error("clocks on during load");

  property p_hard_pin;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_RUN && !hard_reset_pin_n) |=> st_q == ST_LOAD;
  endproperty
  a_hard_pin: assert property (p_hard_pin) // RULE5
    else $error("pin did not start reload");

  property p_no_ready_load;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_LOAD) |-> !pready || $past(st_q) == ST_RUN;
  endproperty
  a_no_ready_load: assert property (p_no_ready_load) // RULE2
    else $error("bus answered during load");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_RUN && mon[0]) |=> flag_q[0];
  endproperty
  a_sticky: assert property (p_sticky) // RULE15
    else $error("flag not set by status");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    irq_pin_n == ~|($past(flag_d) & ~$past(mask_d));
  endproperty
  a_irq: assert property (p_irq) // RULE21
    else $error("irq mismatch");

  property p_lock_pin;
    @(posedge pclk) disable iff (!presetn)
    lock_lost ##1 lock_lost |-> !lock_fail_pin_n;
  endproperty
  a_lock_pin: assert property (p_lock_pin) // RULE14
    else $error("lock pin wrong");

  property p_pin_sel;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q[`B_REG_SEL] |=> active_ref == $past(in_sel_pins);
  endproperty
  a_pin_sel: assert property (p_pin_sel) // RULE11
    else $error("pin select not followed");

  property p_rdiv_even;
    @(posedge pclk) disable iff (!presetn)
    st_q == ST_RUN |-> rd_q[0][0] == 1'b0 && rd_q[0] >= `RDIV_MIN;
  endproperty
  a_rdiv_even: assert property (p_rdiv_even) // RULE7
    else $error("divider odd or too small");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) // RULE2
    else $error("pready longer than one cycle");

  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) // RULE2
    else $error("pslverr outside answer");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_RUN && !(wr && paddr == `A_FLAG)) |=>
      (flag_q & $past(flag_q)) == $past(flag_q);
  endproperty
  a_flag_hold: assert property (p_flag_hold) // RULE15
    else $error("flag dropped without clear");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == `A_FLAG && mon == '0) |=>
      flag_q == ($past(flag_q) & $past(pwdata[NS-1:0]));
  endproperty
  a_flag_clear: assert property (p_flag_clear) // RULE16
    else $error("zero write did not clear flag");

  property p_lock_release;
    @(posedge pclk) disable iff (!presetn)
    !lock_lost |=> lock_fail_pin_n;
  endproperty
  a_lock_release: assert property (p_lock_release) // RULE14
    else $error("lock pin low while locked");

  property p_reg_sel;
    @(posedge pclk) disable iff (!presetn)
    ctrl_q[`B_REG_SEL] |=> active_ref == $past(insel_q);
  endproperty
  a_reg_sel: assert property (p_reg_sel) // RULE10
    else $error("register select not followed");

  property p_soft_apply;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_SOFT) |=> crystal_ext_mode == $past(ctrl_q[`B_XTAL_EXT]);
  endproperty
  a_soft_apply: assert property (p_soft_apply) // RULE9
    else $error("clock mode not applied");

  property p_soft_back;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_SOFT) |=> st_q == ST_RUN;
  endproperty
  a_soft_back: assert property (p_soft_back) // RULE6
    else $error("soft reset did not return");

  property p_soft_keep;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_SOFT) |=> mask_q == $past(mask_q);
  endproperty
  a_soft_keep: assert property (p_soft_keep) // RULE6
    else $error("soft reset reloaded a register");

  property p_hard_bit;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == `A_CTRL && pwdata[`B_HARD] && !pwdata[`B_SOFT])
      |=> ##1 st_q == ST_LOAD;
  endproperty
  a_hard_bit: assert property (p_hard_bit) // RULE5
    else $error("hard reset bit did not reload");

  property p_load_cfg;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_LOAD && cnt_q < 16'(`NVM_WORDS)) |=> mask_q == NS'(`RST_MASK);
  endproperty
  a_load_cfg: assert property (p_load_cfg) // RULE4
    else $error("mask not reloaded");

  property p_outs_off;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_LOAD) |-> out_enable == '0;
  endproperty
  a_outs_off: assert property (p_outs_off) // RULE3
    else $error("outputs on during load");
endmodule
`default_nettype wire

// *** sim/host_model.sv ***
// host side: apb master issuing one register transfer at a time
// assumes pclk from the bench; the slave may stall through its load
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // apb
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e, output bit to);
    to = 1'b1;
    r = 32'h00000000;
    e = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : ~d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken only at the rising edge that sees pready high
    for (int n = 0; n < 3000 && to; n++) begin
      @(posedge pclk);
      if (pready) begin
        to = 1'b0;
        r = prdata;
        e = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// bench top: drives pins and monitors, host model does register traffic
// assumes the block's load count is shortened to 16 cycles
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_defines.svh"
module tb_top;
  import clkgen_pkg::*;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         hard_reset_pin_n = 1'b1;
  logic [1:0]   in_sel_pins = 2'h3;
  logic [4:0]   signal_missing = 5'h00;
  logic         lock_lost = 1'b0;
  logic         psel, penable, pwrite, pready, pslverr, rd_e;
  logic         lock_fail_pin_n, irq_pin_n, clocks_enable;
  logic         crystal_ext_mode;
  logic [1:0]   active_ref;
  logic [11:0]  paddr, out_single_ended, out_enable;
  logic [47:0]  out_xsel;
  logic [299:0] out_rdiv;
  logic [31:0]  pwdata, prdata, rd_d, f, x;
  logic [31:0]  seed = 32'hF8AB3946;
  logic [24:0]  v;
  int           n_fail = 0;
  int           checks = 0;
  int           k;
  always #20 pclk = ~pclk;
  clock_gen_ctrl_status #(.INIT_CYCLES(16)) u_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .hard_reset_pin_n, .in_sel_pins, .signal_missing,
    .lock_lost, .lock_fail_pin_n, .irq_pin_n, .clocks_enable,
    .crystal_ext_mode, .active_ref, .out_single_ended, .out_enable,
    .out_xsel, .out_rdiv);
  host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // odd or out-of-range divider values leave the old one in place
  function automatic logic [24:0] rdiv_exp(input logic [24:0] nv, ov);
    return (!nv[0] && nv >= `RDIV_MIN && nv <= `RDIV_MAX) ? nv : ov;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xf(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    bit to;
    u_host.xfer(w, a, d, rd_d, rd_e, to);
    if (to) begin
      n_fail++;
      $display("mismatch pready exp 1 got 0");
      summarize();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk("clk_en_load", 0, 32'(clocks_enable));
    xf(0, `A_CTRL, 0);
    chk("init_done", 1, 32'(rd_d[`B_INIT_DONE]));
    chk("clk_en_run", 1, 32'(clocks_enable));
    $display("test load done");
    for (int i = 0; i < 4; i++) begin
      xf(1, `A_INSEL, i);
      xf(1, `A_CTRL, 32'hA | ((i & 1) << `B_XTAL_EXT));
      cyc(2);
      chk("reg_ref", i, 32'(active_ref));
      chk("ext_mode", i & 1, 32'(crystal_ext_mode));
    end
    xf(1, `A_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      in_sel_pins <= 2'(i);
      cyc(3);
      chk("pin_ref", i, 32'(active_ref));
    end
    $display("test select done");
    for (int i = 0; i < 10; i++) begin
      k = 32'(rnd() % 6);
      v = i == 0 ? `RDIV_MIN : i == 1 ? `RDIV_MAX : 25'(rnd());
      x = rnd() % 5;
      f = rnd();
      xf(1, 12'(`A_RDIV + 4 * k), 32'h4);
      xf(1, 12'(`A_RDIV + 4 * k), 32'(v));
      xf(1, 12'(`A_XSEL + 4 * k), x);
      xf(1, `A_FMT, f & 32'hFFF);
      xf(1, `A_OUTEN, f >> 12);
      xf(1, `A_CTRL, 32'h2);
      cyc(2);
      chk("rdiv", 32'(rdiv_exp(v, 25'h4)), 32'(out_rdiv[k*25 +: 25]));
      chk("xsel", x, 32'(out_xsel[k*4 +: 4]));
      chk("fmt", f & 32'hFFF, 32'(out_single_ended));
      chk("outen", (f >> 12) & 32'hFFF, 32'(out_enable));
    end
    $display("test config done");
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      if (i < 5)
        signal_missing <= 5'(1 << i);
      else
        lock_lost <= 1'b1;
      cyc(3);
      if (i == 5)
        chk("lock_pin", 0, 32'(lock_fail_pin_n));
      xf(0, `A_STATUS, 0);
      chk("status", 1 << i, rd_d & 32'h3F);
      @(posedge pclk);
      signal_missing <= 5'h00;
      lock_lost <= 1'b0;
      xf(0, `A_FLAG, 0);
      chk("flag", 1 << i, rd_d & 32'h3F);
      chk("irq_set", 0, 32'(irq_pin_n));
      xf(1, `A_MASK, 1 << i);
      cyc(2);
      chk("irq_mask", 1, 32'(irq_pin_n));
      xf(1, `A_MASK, 0);
      xf(1, `A_FLAG, ~(32'h1 << i));
      cyc(2);
      chk("irq_clear", 1, 32'(irq_pin_n));
      xf(0, `A_FLAG, 0);
      chk("flag_clr", 0, rd_d & 32'h3F);
    end
    $display("test monitor done");
    xf(1, `A_MASK, 32'h15);
    @(posedge pclk);
    hard_reset_pin_n <= 1'b0;
    cyc(2);
    @(posedge pclk);
    hard_reset_pin_n <= 1'b1;
    cyc(2);
    chk("pin_reset", 0, 32'(clocks_enable));
    xf(0, `A_MASK, 0);
    chk("mask_reload", 32'(`RST_MASK), rd_d);
    xf(1, `A_CTRL, 32'h1);
    cyc(2);
    chk("bit_reset", 0, 32'(clocks_enable));
    xf(0, `A_CTRL, 0);
    chk("reload_done", 1, 32'(rd_d[`B_INIT_DONE]));
    xf(0, 12'hFFC, 0);
    chk("unmapped_err", 1, 32'(rd_e));
    chk("unmapped_data", 0, rd_d);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
